// *** src/fsc_bus_cycle.sv ***
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: start pulses only while idle
// Notes:   done pulses as the hold phase ends, in the same cycle the engine is back in idle
`timescale 1ns/1ps
module fsc_bus_cycle (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      ce,
   input  wire logic                      start,
   input  wire fsc_pkg::fsc_cyc_req_s     req,
   input  wire logic [fsc_pkg::DQ_W-1:0]  dq_i,
   output fsc_pkg::fsc_pins_s             pins,
   output logic                           done,
   output logic [fsc_pkg::DQ_W-1:0]       rdata
);

   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD} fsc_ph_e;

   typedef struct packed {
      fsc_ph_e                  ph;
      logic [3:0]               cnt;
      logic                     write;
      fsc_pkg::fsc_pins_s       pins;
      logic                     done;
      logic [fsc_pkg::DQ_W-1:0] rdata;
   } fsc_cyc_s;

   fsc_cyc_s st_r;
   fsc_cyc_s st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      case (st_r.ph)
         PH_IDLE: begin
            if (start) begin
               st_nxt.ph         = PH_SETUP;
               st_nxt.cnt        = fsc_pkg::SETUP_CYC - 4'h1;
               st_nxt.write      = req.write;
               st_nxt.pins.addr  = req.addr;
               st_nxt.pins.dq_o  = req.data;
               st_nxt.pins.dq_oe = req.write;
               st_nxt.pins.ce_n  = 1'b0;
            end
         end
         PH_SETUP: begin
            if (st_r.cnt == 4'h0) begin
               st_nxt.ph        = PH_PULSE;
               st_nxt.cnt       = fsc_pkg::PULSE_CYC - 4'h1;
               st_nxt.pins.we_n = ~st_r.write;
               st_nxt.pins.oe_n = st_r.write;
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         PH_PULSE: begin
            if (st_r.cnt == 4'h0) begin
               st_nxt.ph        = PH_HOLD;
               st_nxt.cnt       = fsc_pkg::HOLD_CYC - 4'h1;
               st_nxt.pins.we_n = 1'b1;
               st_nxt.pins.oe_n = 1'b1;
               if (!st_r.write) begin
                  st_nxt.rdata = dq_i;
               end
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         PH_HOLD: begin
            if (st_r.cnt == 4'h0) begin
               st_nxt.ph         = PH_IDLE;
               st_nxt.pins.ce_n  = 1'b1;
               st_nxt.pins.dq_oe = 1'b0;
               st_nxt.done       = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - 4'h1;
            end
         end
         default: begin
            st_nxt.ph = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r           <= '0;
         st_r.ph        <= PH_IDLE;
         st_r.pins.ce_n <= 1'b1;
         st_r.pins.we_n <= 1'b1;
         st_r.pins.oe_n <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign pins  = st_r.pins;
   assign done  = st_r.done;
   assign rdata = st_r.rdata;

endmodule

// *** src/fsc_ctrl.sv ***
// Purpose: host controller for a boot-block flash, status and protection
// Assumes: flash pins synchronous to clk, register port as a plain slave
// Notes:   polls status after program, erase, suspend and resume
`timescale 1ns/1ps
module fsc_ctrl (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         ce,
   input  wire logic [fsc_pkg::RA_W-1:0]     reg_addr,
   input  wire logic [fsc_pkg::RD_W-1:0]     reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [fsc_pkg::RD_W-1:0]          reg_rdata,
   output fsc_pkg::fsc_pins_s                flash_pins,
   input  wire logic [fsc_pkg::DQ_W-1:0]     flash_dq_i,
   output logic                              flash_boot_unlock,
   output logic                              reset_powerdown_pin_n,
   output logic                              high_unlock_req
);

   typedef enum logic [2:0] {S_IDLE, S_WR1, S_WR2, S_RD, S_EVAL} fsc_mst_e;

   typedef struct packed {
      fsc_mst_e                    state;
      fsc_pkg::fsc_op_e            op;
      logic [fsc_pkg::ADDR_W-1:0]  addr;
      logic [fsc_pkg::DQ_W-1:0]    data;
      logic [2:0]                  ctrl;
      logic                        start;
      fsc_pkg::fsc_cyc_req_s       req;
      logic                        err_pending;
      logic                        refused;
      logic                        suspended;
      logic                        erase_err;
      logic                        prog_err;
      logic                        supply_low;
      logic [7:0]                  last_sr;
      logic [fsc_pkg::DQ_W-1:0]    result;
      logic [fsc_pkg::RD_W-1:0]    rdata;
   } fsc_main_s;

   fsc_main_s                st_r;
   fsc_main_s                st_nxt;
   logic                     cyc_done;
   logic [fsc_pkg::DQ_W-1:0] cyc_rdata;
   fsc_pkg::fsc_eval_s       ev;
   fsc_pkg::fsc_op_e         wr_op;
   logic                     cmd_wr;
   logic                     ev_load;

   ////////////////////////////////////////////////////////////////////////
   // bus cycle engine and status decode

   fsc_bus_cycle u_cycle (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .start (st_r.start),
      .req   (st_r.req),
      .dq_i  (flash_dq_i),
      .pins  (flash_pins),
      .done  (cyc_done),
      .rdata (cyc_rdata)
   );

   assign ev_load = cyc_done && (st_r.state == S_RD) &&
                    (st_r.op != fsc_pkg::OP_READ_STATUS) &&
                    (st_r.op != fsc_pkg::OP_READ_ARRAY);

   fsc_status_eval u_eval (
      .clk    (clk),
      .reset  (reset),
      .ce     (ce),
      .load   (ev_load),
      .sr_raw (cyc_rdata[7:0]),
      .ev     (ev)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   assign wr_op  = fsc_pkg::fsc_op_e'(reg_wdata[2:0]);
   assign cmd_wr = reg_wr && (reg_addr == fsc_pkg::REG_CMD);

   always_comb begin
      st_nxt       = st_r;
      st_nxt.start = 1'b0;
      st_nxt.rdata = '0;
      case (st_r.state)
         S_IDLE: begin
            if (reg_wr && reg_addr == fsc_pkg::REG_ADDR) begin
               st_nxt.addr = reg_wdata[fsc_pkg::ADDR_W-1:0];
            end
            if (reg_wr && reg_addr == fsc_pkg::REG_DATA) begin
               st_nxt.data = reg_wdata[fsc_pkg::DQ_W-1:0];
            end
            if (reg_wr && reg_addr == fsc_pkg::REG_CTRL) begin
               st_nxt.ctrl = reg_wdata[2:0];
            end
            if (cmd_wr) begin
               if (((wr_op == fsc_pkg::OP_PROGRAM ||
                     wr_op == fsc_pkg::OP_ERASE) &&
                    st_r.err_pending) ||
                   (wr_op == fsc_pkg::OP_RESUME && !st_r.suspended) ||
                   wr_op == fsc_pkg::OP_NONE) begin
                  st_nxt.refused = 1'b1;
               end else begin
                  st_nxt.refused     = 1'b0;
                  st_nxt.op          = wr_op;
                  st_nxt.state       = S_WR1;
                  st_nxt.start       = 1'b1;
                  st_nxt.req.write   = 1'b1;
                  st_nxt.req.addr    = st_r.addr;
                  st_nxt.req.data    = '0;
                  case (wr_op)
                     fsc_pkg::OP_PROGRAM:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_PROGRAM;
                     fsc_pkg::OP_ERASE:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_ERASE_SETUP;
                     fsc_pkg::OP_SUSPEND:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_SUSPEND;
                     fsc_pkg::OP_RESUME:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_CONFIRM;
                     fsc_pkg::OP_CLEAR:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_CLEAR_STAT;
                     fsc_pkg::OP_READ_STATUS:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_READ_STATUS;
                     default:
                        st_nxt.req.data[7:0] = fsc_pkg::CODE_READ_ARRAY;
                  endcase
               end
            end
         end
         S_WR1: begin
            if (cyc_done) begin
               st_nxt.start     = 1'b1;
               st_nxt.req.addr  = st_r.addr;
               case (st_r.op)
                  fsc_pkg::OP_PROGRAM: begin
                     st_nxt.state    = S_WR2;
                     st_nxt.req.data = st_r.data;
                  end
                  fsc_pkg::OP_ERASE: begin
                     st_nxt.state    = S_WR2;
                     st_nxt.req.data = {8'h00, fsc_pkg::CODE_CONFIRM};
                  end
                  fsc_pkg::OP_CLEAR: begin
                     st_nxt.start       = 1'b0;
                     st_nxt.state       = S_IDLE;
                     st_nxt.err_pending = 1'b0;
                     st_nxt.erase_err   = 1'b0;
                     st_nxt.prog_err    = 1'b0;
                     st_nxt.supply_low  = 1'b0;
                  end
                  fsc_pkg::OP_RESUME: begin
                     st_nxt.state     = S_RD;
                     st_nxt.req.write = 1'b0;
                     st_nxt.suspended = 1'b0;
                  end
                  default: begin
                     st_nxt.state     = S_RD;
                     st_nxt.req.write = 1'b0;
                  end
               endcase
            end
         end
         S_WR2: begin
            if (cyc_done) begin
               // status mode follows automatically, any address reads it
               st_nxt.state     = S_RD;
               st_nxt.start     = 1'b1;
               st_nxt.req.write = 1'b0;
            end
         end
         S_RD: begin
            if (cyc_done) begin
               if (st_r.op == fsc_pkg::OP_READ_STATUS ||
                   st_r.op == fsc_pkg::OP_READ_ARRAY) begin
                  st_nxt.result = cyc_rdata;
                  st_nxt.state  = S_IDLE;
               end else begin
                  st_nxt.state = S_EVAL;
               end
            end
         end
         S_EVAL: begin
            if (ev.valid) begin
               st_nxt.last_sr = ev.sr;
               if (!ev.ready) begin
                  // busy: error bits are not meaningful yet
                  st_nxt.state     = S_RD;
                  st_nxt.start     = 1'b1;
                  st_nxt.req.write = 1'b0;
               end else begin
                  st_nxt.state     = S_IDLE;
                  st_nxt.suspended = ev.suspend;
                  st_nxt.erase_err = st_r.erase_err | ev.erase_err;
                  st_nxt.prog_err  = st_r.prog_err | ev.prog_err;
                  st_nxt.supply_low = st_r.supply_low | ev.supply_low;
                  if (ev.erase_err || ev.prog_err || ev.supply_low) begin
                     st_nxt.err_pending = 1'b1;
                  end
               end
            end
         end
         default: begin
            st_nxt.state = S_IDLE;
         end
      endcase
      if (st_r.state != S_IDLE && cmd_wr) begin
         st_nxt.refused = 1'b1;
      end
      if (reg_rd) begin
         case (reg_addr)
            fsc_pkg::REG_ADDR:
               st_nxt.rdata[fsc_pkg::ADDR_W-1:0] = st_r.addr;
            fsc_pkg::REG_DATA:
               st_nxt.rdata[fsc_pkg::DQ_W-1:0] = st_r.data;
            fsc_pkg::REG_CTRL:
               st_nxt.rdata[2:0] = st_r.ctrl;
            fsc_pkg::REG_STATUS: begin
               st_nxt.rdata[fsc_pkg::ST_BUSY]       = st_r.state != S_IDLE;
               st_nxt.rdata[fsc_pkg::ST_ERR_PEND]   = st_r.err_pending;
               st_nxt.rdata[fsc_pkg::ST_REFUSED]    = st_r.refused;
               st_nxt.rdata[fsc_pkg::ST_SUSPENDED]  = st_r.suspended;
               st_nxt.rdata[fsc_pkg::ST_ERASE_ERR]  = st_r.erase_err;
               st_nxt.rdata[fsc_pkg::ST_PROG_ERR]   = st_r.prog_err;
               st_nxt.rdata[fsc_pkg::ST_SUPPLY_LOW] = st_r.supply_low;
               st_nxt.rdata[fsc_pkg::ST_LAST_SR +: 8] = st_r.last_sr;
            end
            fsc_pkg::REG_RESULT:
               st_nxt.rdata[fsc_pkg::DQ_W-1:0] = st_r.result;
            default:
               st_nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r       <= '0;
         st_r.state <= S_IDLE;
         st_r.ctrl  <= fsc_pkg::CTRL_RESET;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata             = st_r.rdata;
   assign flash_boot_unlock     = st_r.ctrl[fsc_pkg::CTRL_BOOT_UNLOCK];
   assign reset_powerdown_pin_n = st_r.ctrl[fsc_pkg::CTRL_RUN];
   assign high_unlock_req       = st_r.ctrl[fsc_pkg::CTRL_HV_UNLOCK];

   ////////////////////////////////////////////////////////////////////////
   // checks

   chk_reserved_masked: assert property (
      @(posedge clk) disable iff (reset)
      ev.sr[2:0] == 3'h0 && st_r.last_sr[2:0] == 3'h0)
      else $error("reserved status bits not masked");

   chk_ready_first: assert property (
      @(posedge clk) disable iff (reset)
      (ce && st_r.state == S_EVAL && ev.valid && !ev.ready)
      |=> (st_r.state == S_RD && $stable(st_r.err_pending)))
      else $error("errors evaluated while engine busy");

   chk_low_supply_holds: assert property (
      @(posedge clk) disable iff (reset)
      (ce && st_r.state == S_EVAL && ev.valid && ev.ready &&
       ev.supply_low) |=> st_r.err_pending [*2])
      else $error("supply low did not block further attempts");

   chk_refuse_on_error: assert property (
      @(posedge clk) disable iff (reset)
      (ce && st_r.state == S_IDLE && st_r.err_pending && cmd_wr &&
       (wr_op == fsc_pkg::OP_PROGRAM || wr_op == fsc_pkg::OP_ERASE))
      |=> (st_r.state == S_IDLE && st_r.refused))
      else $error("retry started without clearing status");

   chk_clear_first: assert property (
      @(posedge clk) disable iff (reset)
      (st_r.state == S_WR1 && st_r.start &&
       (st_r.op == fsc_pkg::OP_PROGRAM || st_r.op == fsc_pkg::OP_ERASE))
      |-> !st_r.err_pending)
      else $error("program or erase issued with error pending");

   chk_clear_status: assert property (
      @(posedge clk) disable iff (reset)
      (ce && st_r.state == S_WR1 && st_r.op == fsc_pkg::OP_CLEAR &&
       cyc_done) |=> (!st_r.err_pending && st_r.state == S_IDLE))
      else $error("clear status did not release the error");

   cov_program_ok: cover property (
      @(posedge clk) disable iff (reset)
      st_r.state == S_EVAL && st_r.op == fsc_pkg::OP_PROGRAM &&
      ev.valid && ev.ready && !ev.prog_err);

   cov_erase_err: cover property (
      @(posedge clk) disable iff (reset)
      st_r.state == S_EVAL && st_r.op == fsc_pkg::OP_ERASE &&
      ev.valid && ev.ready && ev.erase_err);

   cov_suspend: cover property (
      @(posedge clk) disable iff (reset)
      st_r.state == S_EVAL && st_r.op == fsc_pkg::OP_SUSPEND &&
      ev.valid && ev.ready && ev.suspend);

endmodule

// *** src/fsc_pkg.sv ***
// Purpose: shared constants and types of the flash status controller
// Assumes: 100 MHz clock, 16-bit flash data bus, 20-bit flash address
// Notes:   status bit positions and command codes of the flash part
package fsc_pkg;

   localparam int ADDR_W = 20;
   localparam int DQ_W   = 16;
   localparam int RA_W   = 3;
   localparam int RD_W   = 32;

   // flash command codes
   localparam logic [7:0] CODE_READ_ARRAY  = 8'hFF;
   localparam logic [7:0] CODE_PROGRAM     = 8'h40;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CODE_CONFIRM     = 8'hD0;
   localparam logic [7:0] CODE_SUSPEND     = 8'hB0;
   localparam logic [7:0] CODE_READ_STATUS = 8'h70;
   localparam logic [7:0] CODE_CLEAR_STAT  = 8'h50;

   // flash status byte
   localparam int         SR_READY      = 7;
   localparam int         SR_SUSPEND    = 6;
   localparam int         SR_ERASE_ERR  = 5;
   localparam int         SR_PROG_ERR   = 4;
   localparam int         SR_SUPPLY_LOW = 3;
   localparam logic [7:0] SR_USED_MASK  = 8'hF8;

   // controller registers (word index on the register port)
   localparam logic [RA_W-1:0] REG_CMD    = 3'h0;
   localparam logic [RA_W-1:0] REG_ADDR   = 3'h1;
   localparam logic [RA_W-1:0] REG_DATA   = 3'h2;
   localparam logic [RA_W-1:0] REG_CTRL   = 3'h3;
   localparam logic [RA_W-1:0] REG_STATUS = 3'h4;
   localparam logic [RA_W-1:0] REG_RESULT = 3'h5;

   // control register fields and reset value
   localparam int         CTRL_BOOT_UNLOCK = 0;
   localparam int         CTRL_RUN         = 1;
   localparam int         CTRL_HV_UNLOCK   = 2;
   localparam logic [2:0] CTRL_RESET       = 3'h0;

   // status register fields
   localparam int ST_BUSY       = 0;
   localparam int ST_ERR_PEND   = 1;
   localparam int ST_REFUSED    = 2;
   localparam int ST_SUSPENDED  = 3;
   localparam int ST_ERASE_ERR  = 4;
   localparam int ST_PROG_ERR   = 5;
   localparam int ST_SUPPLY_LOW = 6;
   localparam int ST_LAST_SR    = 8;

   // bus cycle timing
   localparam int         CLK_NS      = 10;
   localparam int         T_SETUP_NS  = 20;
   localparam int         T_PULSE_NS  = 70;
   localparam int         T_HOLD_NS   = 20;
   localparam logic [3:0] SETUP_CYC   = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] PULSE_CYC   = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC    = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {
      OP_NONE, OP_PROGRAM, OP_ERASE, OP_SUSPEND,
      OP_RESUME, OP_CLEAR, OP_READ_STATUS, OP_READ_ARRAY
   } fsc_op_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   dq_o;
      logic              dq_oe;
      logic              ce_n;
      logic              we_n;
      logic              oe_n;
   } fsc_pins_s;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   data;
   } fsc_cyc_req_s;

   typedef struct packed {
      logic [7:0] sr;
      logic       valid;
      logic       ready;
      logic       suspend;
      logic       erase_err;
      logic       prog_err;
      logic       supply_low;
   } fsc_eval_s;

endpackage

// *** src/fsc_status_eval.sv ***
// Purpose: registers and decodes one flash status byte
// Assumes: load pulses when a status read completes
// Notes:   reserved bits are masked before anything looks at them
`timescale 1ns/1ps
module fsc_status_eval (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        load,
   input  wire logic [7:0]  sr_raw,
   output fsc_pkg::fsc_eval_s ev
);

   fsc_pkg::fsc_eval_s st_r;
   fsc_pkg::fsc_eval_s st_nxt;
   logic [7:0]         sr_m;

   always_comb begin
      sr_m              = sr_raw & fsc_pkg::SR_USED_MASK;
      st_nxt            = st_r;
      st_nxt.valid      = load;
      if (load) begin
         st_nxt.sr         = sr_m;
         st_nxt.ready      = sr_m[fsc_pkg::SR_READY];
         st_nxt.suspend    = sr_m[fsc_pkg::SR_SUSPEND];
         st_nxt.erase_err  = sr_m[fsc_pkg::SR_ERASE_ERR];
         st_nxt.prog_err   = sr_m[fsc_pkg::SR_PROG_ERR];
         st_nxt.supply_low = sr_m[fsc_pkg::SR_SUPPLY_LOW];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign ev = st_r;

endmodule

// *** test/fsc_flash_model.sv ***
// Purpose: behavioural boot-block flash, status and lock side
// Assumes: writes taken at the rising edge of we_n
// Notes:   boot block is the lowest 64K words
`timescale 1ns/1ps
module fsc_flash_model (
   input  wire logic               clk,
   input  wire fsc_pkg::fsc_pins_s pins,
   input  wire logic               boot_unlock,
   input  wire logic               rp_n,
   input  wire logic               hv,
   input  wire logic               supply_ok,
   output logic [15:0]             dq = 16'h0000
);
   logic       we_q = 1'b1;
   logic       bad;
   logic [7:0] c1 = 8'hFF;
   logic [7:0] cd;
   logic [6:3] st = 4'h0;
   int         busy = 0;
   assign cd = pins.dq_o[7:0];
   assign bad = !supply_ok || st[3]
      || (pins.addr[19:16] == 4'h0 && !boot_unlock && !hv);
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      we_q <= pins.we_n;
      if (busy > 0) busy <= busy - 1;
      // released lines toggle every cycle
      dq <= (pins.oe_n | pins.ce_n) ? ~dq
         : {~dq[15:8], busy == 0, st, 3'h5};
      if (!rp_n) begin
         st <= 4'h0;
         c1 <= 8'hFF;
      end else if (pins.we_n && !we_q) begin
         c1 <= cd;
         if (c1 == 8'h40 || c1 == 8'h20) begin
            c1 <= 8'hFF;
            busy <= 20;
            st[3] <= st[3] | !supply_ok;
            if (c1 == 8'h40) st[4] <= st[4] | bad;
            else if (cd != 8'hD0) st[5:4] <= 2'h3;
            else st[5] <= st[5] | bad;
         end else if (cd == 8'h50) st[5:3] <= 3'h0;
         else if (cd == 8'hB0 && busy > 0) begin
            st[6] <= 1'b1;
            busy <= 0;
         end else if (cd == 8'hD0) st[6] <= 1'b0;
      end
   end
endmodule

// *** test/tb_fsc_ctrl.sv ***
// Purpose: self-checking bench of the flash status controller
// Assumes: fsc_flash_model on the flash pins
// Notes:   expected status kept in bench flags
`timescale 1ns/1ps
module tb_fsc_ctrl;
   logic               clk = 1'b0;
   logic               reset = 1'b1;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic               sup = 1'b1;
   logic [2:0]         reg_addr = 3'h0;
   logic [2:0]         ctrl;
   logic [31:0]        reg_wdata = 32'h00000000;
   logic [31:0]        reg_rdata, s;
   logic [31:0]        rnd = 32'h00013CF2;
   logic [15:0]        dq;
   logic               unl, rp_n, hv, ee, pe, vl;
   int                 n_errors = 0;
   int                 n_compared = 0;
   fsc_pkg::fsc_pins_s pins;
   initial forever #5 clk = ~clk;
   fsc_ctrl i_fsc_ctrl (.clk(clk), .reset(reset), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_pins(pins),
      .flash_dq_i(dq), .flash_boot_unlock(unl),
      .reset_powerdown_pin_n(rp_n), .high_unlock_req(hv));
   fsc_flash_model i_fsc_flash_model (.clk(clk), .pins(pins), .dq(dq),
      .boot_unlock(unl), .rp_n(rp_n), .hv(hv), .supply_ok(sup));
   ////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 s = reg_rdata;
   endtask
   task automatic setc(input logic [2:0] v);
      ctrl = v;
      wr(fsc_pkg::REG_CTRL, {29'h0, v});
      @(posedge clk);
      #1 check("pins", {13'h0, hv, rp_n, unl}, {13'h0, v});
   endtask
   task automatic op(input logic [2:0] c, input logic [19:0] a,
                     input logic rf);
      logic        bad;
      logic        rj;
      logic [15:0] m;
      rj = c < 3'h3 && (ee | pe | vl);
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      wr(fsc_pkg::REG_ADDR, {12'h000, a});
      wr(fsc_pkg::REG_DATA, {16'h0000, rnd[15:0]});
      wr(fsc_pkg::REG_CMD, {29'h0, c});
      if (rf) wr(fsc_pkg::REG_CMD, 32'h00000002);
      s = 32'h00000001;
      for (int n = 0; n < 300 && s[0] !== 1'b0; n++)
         rd(fsc_pkg::REG_STATUS);
      bad = !rj && (!sup || (a[19:16] == 4'h0 && !ctrl[0] && !ctrl[2]));
      if (c == 3'h5) {ee, pe, vl} = 3'h0;
      if (c == 3'h1) pe |= bad;
      if (c == 3'h2) ee |= bad;
      if (c < 3'h3 && !rj) vl |= !sup;
      m = (c < 3'h3) ? 16'hFFFF : 16'h007F;
      check("status", s[15:0] & m, m & {2'h2, ee, pe, vl, 4'h0, vl, pe,
            ee, 1'b0, rf | rj | c == 3'h4, ee | pe | vl, 1'b0});
      if (c == 3'h6) begin
         rd(fsc_pkg::REG_RESULT);
         check("result", 16'(s[7:3]), {11'h0, 2'h2, ee, pe, vl});
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {ee, pe, vl} = 3'h0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(fsc_pkg::REG_CTRL);
      check("ctrl", s[15:0], {13'h0, fsc_pkg::CTRL_RESET});
      rd(3'h7);
      check("unmapped", s[15:0], 16'h0000);
      setc(3'h2);
      op(3'h1, 20'h40010, 1'b0);
      op(3'h1, 20'h00010, 1'b0);
      op(3'h6, 20'h00000, 1'b0);
      op(3'h5, 20'h00000, 1'b0);
      op(3'h2, 20'h00010, 1'b0);
      op(3'h1, 20'h40010, 1'b0);
      op(3'h5, 20'h00000, 1'b0);
      setc(3'h6);
      op(3'h2, 20'h00010, 1'b0);
      setc(3'h3);
      op(3'h1, 20'h00020, 1'b1);
      op(3'h3, 20'h00000, 1'b0);
      op(3'h7, 20'h00000, 1'b0);
      op(3'h4, 20'h00000, 1'b0);
      sup <= 1'b0;
      op(3'h2, 20'h50000, 1'b0);
      op(3'h5, 20'h00000, 1'b0);
      sup <= 1'b1;
      op(3'h1, 20'h50000, 1'b0);
      tally_and_finish();
   end
   initial begin
      #400000;
      n_errors++;
      tally_and_finish();
   end
endmodule
